// file: rtl/uart_basic_clock_gen.sv
/*
 Prescaler giving the basic clock as a one-cycle enable pulse.
 Assumes the select code changes only while the enable is low.
*/
`timescale 1ns/1ps
`include "uart_consts.svh"
module uart_basic_clock_gen
#(
	parameter int CNT_W = 11
)
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic enable,
	input wire logic [3:0] select,
	output logic fuclk_en
);
	import uart_pkg::*;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W:0] span;
	logic [CNT_W-1:0] mask;
	logic prohibited;

	assign span = (CNT_W+1)'(1) << select;
	assign mask = CNT_W'(span - (CNT_W+1)'(1));
	assign prohibited = select > `PRESCALE_MAX_CODE;

	// ********************
	// Divider
	// ********************
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_reg <= '0;
			fuclk_en <= 1'b0;
		end
		else if (!enable || prohibited)
		begin
			// Held low while the channel is off
			cnt_reg <= '0;
			fuclk_en <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_reg + CNT_W'(1);
			fuclk_en <= (cnt_reg & mask) == mask;
		end
	end
endmodule

// file: rtl/uart_channel.sv
/*
 One asynchronous serial channel: AXI4-Lite registers, prescaler, bit rate
 counters, noise filter, parity transmit and receive, error routing.
 Assumes serial_in_line is synchronous to clock and a single-beat master.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "uart_consts.svh"
// Summary of operation
// - Merge bit 0: errors on own interrupt
// - Merge bit 1: errors on completion interrupt
// - Even parity transmit makes ones even
// - Even parity receive flags odd count
// - Odd parity transmit makes ones odd
// - Odd parity receive flags even count
// - Zero parity transmits parity bit zero
// - Zero parity receive never flags error
// - No parity: no bit, no error
// - Filter updates after two agreeing samples
// - One-clock input pulses are dropped
// - Receive lags line by two basic clocks
// - Prescaler plus separate transmit, receive counters
// - Channel off holds basic clock low
// - Select code picks divide by power two
// - Select register four bits wide, resets zero
// - Counter divisor from divisor register
// - Reading status clears error flags
// - Overrun leaves receive buffer unchanged
// - Bit rate is basic clock over 2k
module uart_channel
#(
	parameter logic [31:0] CKSEL_INDEX = `CKSEL_CH0_IDX
)
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic serial_in_line,
	output logic serial_out_line,
	output logic rx_done_irq,
	output logic rx_error_irq
);
	import uart_pkg::*;

	// ********************
	// Helpers
	// ********************
	function automatic reg_sel_type reg_decode(input logic [31:0] addr);
		logic [29:0] idx;
		idx = addr[31:2];
		if (idx == CKSEL_INDEX[29:0]) return SEL_CKSEL;
		else if (idx == 30'(`DIVCTL_CH0_IDX)) return SEL_DIV;
		else if (idx == 30'(`MODE_CH0_IDX)) return SEL_MODE;
		else if (idx == 30'(`RXBUF_CH0_IDX)) return SEL_RXBUF;
		else if (idx == 30'(`RXSTAT_CH0_IDX)) return SEL_RXSTAT;
		else if (idx == 30'(`TXDATA_CH0_IDX)) return SEL_TXDATA;
		else return SEL_NONE;
	endfunction

	function automatic logic par_bit(input logic [7:0] d, input parity_type m);
		case (m)
			PARITY_EVEN: return ^d;
			PARITY_ODD: return ~^d;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic par_err(input logic [7:0] d, input logic p, input parity_type m);
		case (m)
			PARITY_EVEN: return ^{d, p};
			PARITY_ODD: return ~^{d, p};
			default: return 1'b0;
		endcase
	endfunction

	logic [3:0] cksel_reg;
	logic [7:0] div_reg;
	logic [5:0] mode_reg;
	logic [7:0] rxbuf_reg, txdata_reg, rx_shift_reg;
	logic [2:0] stat_reg, rx_bits_reg, tx_bits_reg;
	logic rx_full_reg, rx_par_reg, rx_ph_reg, tx_ph_reg;
	logic samp_a_reg, filt_reg, filt_last_reg;
	logic [7:0] rx_cnt_reg, tx_cnt_reg, k_last;
	logic wr_acc_reg, rd_acc_reg;
	rx_state_type rx_state_reg;
	tx_state_type tx_state_reg;
	reg_sel_type wsel, rsel;
	parity_type parity;
	logic power, rx_on, tx_on, merge, fuclk_en, rx_half, tx_half, rx_finish;
	logic ove_now, fe_now, pe_now, err_now, stat_read, buf_read, tx_start;

	assign power = mode_reg[`MODE_POWER_BIT];
	assign rx_on = power && mode_reg[`MODE_RXEN_BIT];
	assign tx_on = power && mode_reg[`MODE_TXEN_BIT];
	assign merge = mode_reg[`MODE_MERGE_BIT];
	assign parity = parity_type'(mode_reg[`MODE_PAR_LSB +: 2]);
	assign awready = wr_acc_reg;
	assign wready = wr_acc_reg;
	assign arready = rd_acc_reg;
	assign wsel = reg_decode(awaddr);
	assign rsel = reg_decode(araddr);
	// Prohibited small divisors run at the least legal divisor
	assign k_last = ((div_reg < `DIVISOR_MIN) ? `DIVISOR_MIN : div_reg) - 8'h01;

	// ********************
	// Bus slave
	// ********************
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_acc_reg <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end
		else
		begin
			wr_acc_reg <= awvalid && wvalid && !wr_acc_reg && !bvalid;
			if (wr_acc_reg)
			begin
				bvalid <= 1'b1;
				bresp <= (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_acc_reg <= 1'b0;
			rvalid <= 1'b0;
			rresp <= `RESP_OKAY;
			rdata <= 32'h0000_0000;
		end
		else
		begin
			rd_acc_reg <= arvalid && !rd_acc_reg && !rvalid;
			if (rd_acc_reg)
			begin
				rvalid <= 1'b1;
				rresp <= (rsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
				case (rsel)
					SEL_CKSEL: rdata <= {28'h0000000, cksel_reg};
					SEL_DIV: rdata <= {24'h000000, div_reg};
					SEL_MODE: rdata <= {26'h0, mode_reg};
					SEL_RXBUF: rdata <= {24'h000000, rxbuf_reg};
					SEL_RXSTAT: rdata <= {29'h0, stat_reg};
					SEL_TXDATA: rdata <= {24'h000000, txdata_reg};
					default: rdata <= 32'h0000_0000;
				endcase
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

	assign stat_read = rd_acc_reg && rsel == SEL_RXSTAT;
	assign buf_read = rd_acc_reg && rsel == SEL_RXBUF;
	assign tx_start = wr_acc_reg && wstrb[0] && wsel == SEL_TXDATA && tx_on && tx_state_reg == TX_IDLE;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cksel_reg <= `CKSEL_RESET;
			div_reg <= `DIVCTL_RESET;
			mode_reg <= `MODE_RESET;
			txdata_reg <= 8'h00;
		end
		else if (wr_acc_reg && wstrb[0])
		begin
			case (wsel)
				SEL_CKSEL: cksel_reg <= wdata[3:0];
				SEL_DIV: div_reg <= wdata[7:0];
				SEL_MODE: mode_reg <= wdata[5:0];
				SEL_TXDATA: txdata_reg <= tx_start ? wdata[7:0] : txdata_reg;
				default: mode_reg <= mode_reg;
			endcase
		end
	end

	// ********************
	// Basic clock and noise filter
	// ********************
	uart_basic_clock_gen #(.CNT_W(11)) u_prescale
	(
		.clock(clock),
		.arst_n(arst_n),
		.enable(power),
		.select(cksel_reg),
		.fuclk_en(fuclk_en)
	);

	// Two agreeing samples needed, so a one-clock glitch never passes
	// Live sample against the held one keeps the lag at two basic clocks
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			samp_a_reg <= 1'b1;
			filt_reg <= 1'b1;
		end
		else if (fuclk_en)
		begin
			samp_a_reg <= serial_in_line;
			if (serial_in_line == samp_a_reg)
				filt_reg <= samp_a_reg;
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			filt_last_reg <= 1'b1;
		else
			filt_last_reg <= filt_reg;
	end

	// ********************
	// Receiver
	// ********************
	assign rx_half = fuclk_en && rx_cnt_reg == k_last;
	assign rx_finish = rx_state_reg == RX_STOP && rx_half && rx_ph_reg;
	// A buffer read in the finishing cycle frees the buffer in time
	assign ove_now = rx_full_reg && !buf_read;
	assign fe_now = !filt_reg;
	assign pe_now = par_err(rx_shift_reg, rx_par_reg, parity);
	assign err_now = ove_now || fe_now || pe_now;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			rx_cnt_reg <= 8'h00;
		else if (rx_state_reg == RX_IDLE)
			rx_cnt_reg <= 8'h00;
		else if (fuclk_en)
			rx_cnt_reg <= rx_half ? 8'h00 : rx_cnt_reg + 8'h01;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_state_reg <= RX_IDLE;
			rx_ph_reg <= 1'b0;
			rx_bits_reg <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_par_reg <= 1'b0;
		end
		else if (!rx_on)
			rx_state_reg <= RX_IDLE;
		else
		begin
			case (rx_state_reg)
				RX_IDLE:
					if (filt_last_reg && !filt_reg)
						rx_state_reg <= RX_START;
				RX_START:
					if (rx_half)
					begin
						rx_state_reg <= filt_reg ? RX_IDLE : RX_DATA;
						rx_ph_reg <= 1'b0;
						rx_bits_reg <= 3'h0;
					end
				default:
					if (rx_half)
					begin
						rx_ph_reg <= !rx_ph_reg;
						if (rx_ph_reg)
						begin
							case (rx_state_reg)
								RX_DATA:
								begin
									rx_shift_reg <= {filt_reg, rx_shift_reg[7:1]};
									rx_bits_reg <= rx_bits_reg + 3'h1;
									if (rx_bits_reg == 3'h7)
										rx_state_reg <= (parity == PARITY_NONE) ? RX_STOP : RX_PAR;
								end
								RX_PAR:
								begin
									rx_par_reg <= filt_reg;
									rx_state_reg <= RX_STOP;
								end
								default: rx_state_reg <= RX_IDLE;
							endcase
						end
					end
			endcase
		end
	end

	// A flag set in the cycle of a status read survives the read
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stat_reg <= 3'h0;
			rx_full_reg <= 1'b0;
			rxbuf_reg <= 8'h00;
		end
		else
		begin
			stat_reg <= (stat_read ? 3'h0 : stat_reg) |
				(rx_finish ? {pe_now, fe_now, ove_now} : 3'h0);
			rx_full_reg <= (rx_full_reg && !buf_read) || (rx_finish && !ove_now);
			if (rx_finish && !ove_now)
				rxbuf_reg <= rx_shift_reg;
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_done_irq <= 1'b0;
			rx_error_irq <= 1'b0;
		end
		else
		begin
			rx_done_irq <= rx_finish && (merge || !err_now);
			rx_error_irq <= rx_finish && !merge && err_now;
		end
	end

	// ********************
	// Transmitter
	// ********************
	assign tx_half = fuclk_en && tx_cnt_reg == k_last;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			tx_cnt_reg <= 8'h00;
		else if (tx_state_reg == TX_IDLE)
			tx_cnt_reg <= 8'h00;
		else if (fuclk_en)
			tx_cnt_reg <= tx_half ? 8'h00 : tx_cnt_reg + 8'h01;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_state_reg <= TX_IDLE;
			tx_ph_reg <= 1'b0;
			tx_bits_reg <= 3'h0;
			serial_out_line <= 1'b1;
		end
		else if (!tx_on)
		begin
			tx_state_reg <= TX_IDLE;
			serial_out_line <= 1'b1;
		end
		else if (tx_start)
		begin
			tx_state_reg <= TX_START;
			tx_ph_reg <= 1'b0;
			serial_out_line <= 1'b0;
		end
		else if (tx_half)
		begin
			tx_ph_reg <= !tx_ph_reg;
			if (tx_ph_reg)
			begin
				case (tx_state_reg)
					TX_START:
					begin
						tx_state_reg <= TX_DATA;
						tx_bits_reg <= 3'h0;
						serial_out_line <= txdata_reg[0];
					end
					TX_DATA:
						if (tx_bits_reg == 3'h7)
						begin
							// No parity goes straight to the stop bit
							tx_state_reg <= (parity == PARITY_NONE) ? TX_STOP : TX_PAR;
							serial_out_line <= (parity == PARITY_NONE) ? 1'b1 :
								par_bit(txdata_reg, parity);
						end
						else
						begin
							tx_bits_reg <= tx_bits_reg + 3'h1;
							serial_out_line <= txdata_reg[tx_bits_reg + 3'h1];
						end
					TX_PAR:
					begin
						tx_state_reg <= TX_STOP;
						serial_out_line <= 1'b1;
					end
					default: tx_state_reg <= TX_IDLE;
				endcase
			end
		end
	end

	// ********************
	// Checks
	// ********************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_rx_end_err;
		rx_finish && err_now;
	endsequence
	sequence s_err_own_line;
		rx_error_irq && !rx_done_irq;
	endsequence
	property p_err_split;
		s_rx_end_err and !merge |=> s_err_own_line;
	endproperty
	a_err_split: assert property (p_err_split) else $error("error not on own line");
	property p_err_merge;
		$past(merge) |-> !rx_error_irq;
	endproperty
	a_err_merge: assert property (p_err_merge) else $error("error line with merge");
	property p_par_check;
		rx_finish && (parity == PARITY_EVEN || parity == PARITY_ODD) &&
			!stat_reg[`STAT_PE_BIT] |=>
			stat_reg[`STAT_PE_BIT] == $past(^{rx_shift_reg, rx_par_reg} ^ (parity == PARITY_ODD));
	endproperty
	a_par_check: assert property (p_par_check) else $error("parity flag wrong");
	property p_par_quiet;
		rx_finish && (parity == PARITY_ZERO || parity == PARITY_NONE) |-> !pe_now;
	endproperty
	a_par_quiet: assert property (p_par_quiet) else $error("parity flag in quiet mode");
	property p_tx_par;
		tx_state_reg == TX_PAR |-> serial_out_line == par_bit(txdata_reg, parity);
	endproperty
	a_tx_par: assert property (p_tx_par) else $error("parity bit wrong");
	property p_no_par_state;
		parity == PARITY_NONE && $past(parity == PARITY_NONE) |->
			tx_state_reg != TX_PAR && rx_state_reg != RX_PAR;
	endproperty
	a_no_par_state: assert property (p_no_par_state) else $error("parity slot with none");
	property p_filter;
		filt_reg != $past(filt_reg) |-> $past(serial_in_line == samp_a_reg && fuclk_en);
	endproperty
	a_filter: assert property (p_filter) else $error("filter moved early");
	property p_clock_off;
		!power ##1 !power |-> !fuclk_en;
	endproperty
	a_clock_off: assert property (p_clock_off) else $error("basic clock while off");
	property p_stat_clear;
		stat_read && !rx_finish |=> stat_reg == 3'h0;
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");
	property p_ove_keep;
		rx_finish && ove_now |=> $stable(rxbuf_reg) && rx_full_reg;
	endproperty
	a_ove_keep: assert property (p_ove_keep) else $error("buffer loaded on overrun");
endmodule

// file: rtl/uart_consts.svh
/*
 Offsets, field positions and reset values of one serial channel.
 Assumes inclusion by bare name from the package and the channel modules.
*/
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH
// ********************
// Register indices (byte address is four times the index)
// ********************
`define CKSEL_CH0_IDX 32'hfffffa06
`define CKSEL_CH1_IDX 32'hfffffa16
`define CKSEL_CH2_IDX 32'hfffffa26
`define DIVCTL_CH0_IDX 32'hfffffa07
`define MODE_CH0_IDX 32'hfffffa00
`define RXBUF_CH0_IDX 32'hfffffa02
`define RXSTAT_CH0_IDX 32'hfffffa03
`define TXDATA_CH0_IDX 32'hfffffa04
// ********************
// Reset values and fields
// ********************
`define CKSEL_RESET 4'h0
`define DIVCTL_RESET 8'hff
`define MODE_RESET 6'h00
`define MODE_POWER_BIT 0
`define MODE_RXEN_BIT 1
`define MODE_TXEN_BIT 2
`define MODE_PAR_LSB 3
`define MODE_MERGE_BIT 5
`define STAT_OVE_BIT 0
`define STAT_FE_BIT 1
`define STAT_PE_BIT 2
`define PRESCALE_MAX_CODE 4'hb
`define DIVISOR_MIN 8'h08
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// file: rtl/uart_pkg.sv
/*
 Types shared by the serial channel modules.
 Assumes the constants header sits beside it.
*/
package uart_pkg;
	`include "uart_consts.svh"
	// Encoding of the parity field is 0..3 in this order
	typedef enum logic [1:0] {PARITY_NONE, PARITY_ZERO, PARITY_ODD, PARITY_EVEN} parity_type;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_type;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_type;
	typedef enum logic [2:0] {SEL_CKSEL, SEL_DIV, SEL_MODE, SEL_RXBUF, SEL_RXSTAT, SEL_TXDATA,
		SEL_NONE} reg_sel_type;
endpackage

// file: verification/tb_top.sv
/*
 Self-checking bench for one serial channel over AXI4-Lite.
 Assumes the peer model beside it and the design constants header.
*/
`timescale 1ns/1ps
`include "uart_consts.svh"
module tb_top;
	import uart_pkg::*;
	// ********************
	// Signals
	// ********************
	logic clock = 0;
	logic arst_n = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
	logic [3:0] wstrb = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, serial_in_line, serial_out_line;
	logic rx_done_irq, rx_error_irq, cap_par, cap_stop;
	logic [1:0] bresp, rresp;
	logic [7:0] cap_byte;
	logic [15:0] bit_cyc = 16;
	parity_type par_mode = PARITY_NONE;
	int cap_cnt, failures = 0, n_tests = 0, n_done = 0, n_err = 0, n_low = 0;
	logic [31:0] seed = 83922;
	always #2.5 clock = ~clock;
	uart_channel u_dut(.clock(clock), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
		.rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq));
	uart_peer u_peer(.clock(clock), .serial_out_line(serial_out_line), .bit_cyc(bit_cyc),
		.par_mode(par_mode), .serial_in_line(serial_in_line), .cap_byte(cap_byte),
		.cap_par(cap_par), .cap_stop(cap_stop), .cap_cnt(cap_cnt));
	always @(posedge clock)
	begin
		if (rx_done_irq === 1'b1) n_done++;
		if (rx_error_irq === 1'b1) n_err++;
		if (u_dut.filt_reg === 1'b0) n_low++;
	end
	// ********************
	// Helpers and model
	// ********************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] ad(input logic [31:0] idx);
		return idx << 2;
	endfunction
	function automatic logic exp_par(input logic [7:0] d, input int m);
		int ones;
		ones = $countones(d) % 2;
		return (m == 3) ? ones[0] : (m == 2) ? !ones[0] : 1'b0;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge clock);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		chk(bresp, `RESP_OKAY);
		bready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge clock);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clock);
	endtask
	// Power is dropped first so the select never changes under a running clock
	task automatic cfg(input int sel, input int k, input int m, input int merge);
		wr(ad(`MODE_CH0_IDX), 32'h0);
		wr(ad(`CKSEL_CH0_IDX), 32'(sel));
		wr(ad(`DIVCTL_CH0_IDX), 32'(k));
		wr(ad(`MODE_CH0_IDX), 32'(merge * 32 + m * 8 + 7));
		bit_cyc = 16'(2 * k * (1 << sel));
		par_mode = parity_type'(m);
	endtask
	task automatic rx_frame(input logic [7:0] d, input logic flip, input int ed, input int ee);
		int d0;
		int e0;
		d0 = n_done;
		e0 = n_err;
		u_peer.send(d, flip);
		while (n_done + n_err == d0 + e0) @(posedge clock);
		repeat (3) @(posedge clock);
		chk(n_done - d0, ed);
		chk(n_err - e0, ee);
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ********************
	// Tests
	// ********************
	initial
	begin
		repeat (60000) @(posedge clock);
		failures++;
		test_done;
	end
	initial
	begin
		logic [31:0] v, d, e;
		logic [1:0] r;
		int pe, n;
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		rd(ad(`CKSEL_CH0_IDX), v, r);
		chk(v, 32'h0);
		rd(ad(`DIVCTL_CH0_IDX), v, r);
		chk(v, 32'hff);
		rd(32'h10, v, r);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR});
		chk(v, 32'h0);
		wr(ad(`CKSEL_CH0_IDX), 32'hff);
		rd(ad(`CKSEL_CH0_IDX), v, r);
		chk(v, 32'h0f);
		$display("test registers done");
		for (int i = 0; i < 4; i++)
		begin
			// Codes below 3 would push the basic clock past its limit
			cfg(3 + i % 2, 8 + i, i, 0);
			d = rnd();
			n = cap_cnt;
			wr(ad(`TXDATA_CH0_IDX), {24'h0, d[7:0]});
			while (cap_cnt == n) @(posedge clock);
			chk(cap_byte, d[7:0]);
			chk(cap_stop, 1'b1);
			if (i > 0) chk(cap_par, exp_par(d[7:0], i));
			e = rnd();
			pe = (i >= 2);
			rx_frame(e[7:0], 1'b1, 1 - pe, pe);
			rd(ad(`RXSTAT_CH0_IDX), v, r);
			chk(v, 32'(pe) << `STAT_PE_BIT);
			rd(ad(`RXSTAT_CH0_IDX), v, r);
			chk(v, 32'h0);
			rd(ad(`RXBUF_CH0_IDX), v, r);
			chk(v, {24'h0, e[7:0]});
			$display("test parity mode %0d done", i);
		end
		cfg(3, 8, 3, 1);
		e = rnd();
		rx_frame(e[7:0], 1'b1, 1, 0);
		rd(ad(`RXSTAT_CH0_IDX), v, r);
		chk(v, 32'h1 << `STAT_PE_BIT);
		rd(ad(`RXBUF_CH0_IDX), v, r);
		chk(v, {24'h0, e[7:0]});
		d = rnd();
		rx_frame(d[7:0], 1'b0, 1, 0);
		rx_frame(e[7:0], 1'b0, 1, 0);
		rd(ad(`RXSTAT_CH0_IDX), v, r);
		chk(v, 32'h1 << `STAT_OVE_BIT);
		rd(ad(`RXBUF_CH0_IDX), v, r);
		chk(v, {24'h0, d[7:0]});
		$display("test merge and overrun done");
		n = n_done + n_err;
		pe = n_low;
		u_peer.glitch(8);
		repeat (300) @(posedge clock);
		chk(n_low - pe, 0);
		u_peer.glitch(24);
		repeat (300) @(posedge clock);
		chk(32'(n_low > pe), 1);
		chk(n_done + n_err, n);
		wr(ad(`MODE_CH0_IDX), 32'h6);
		n = cap_cnt;
		wr(ad(`TXDATA_CH0_IDX), 32'h55);
		repeat (300) @(posedge clock);
		chk(cap_cnt, n);
		chk(serial_out_line, 1'b1);
		$display("test noise and power off done");
		test_done;
	end
endmodule

// file: verification/uart_peer.sv
/*
 Remote serial peer: sends frames into the channel and decodes its output.
 Assumes the bench sets bit length and parity mode before each frame.
*/
`timescale 1ns/1ps
module uart_peer
(
	input wire logic clock,
	input wire logic serial_out_line,
	input wire logic [15:0] bit_cyc,
	input wire uart_pkg::parity_type par_mode,
	output logic serial_in_line,
	output logic [7:0] cap_byte,
	output logic cap_par,
	output logic cap_stop,
	output int cap_cnt
);
	import uart_pkg::*;
	// ********************
	// Sending side
	// ********************
	function automatic logic par_of(input logic [7:0] d, input logic flip);
		logic p;
		p = (par_mode == PARITY_EVEN) ? ^d : (par_mode == PARITY_ODD) ? ~^d : 1'b0;
		return p ^ flip;
	endfunction
	// Flip corrupts parity on purpose, only when the bench asks for it
	task automatic send(input logic [7:0] d, input logic flip);
		logic [10:0] f;
		int n;
		f = {1'b1, par_of(d, flip), d, 1'b0};
		n = 11;
		if (par_mode == PARITY_NONE)
		begin
			f = {2'b11, d, 1'b0};
			n = 10;
		end
		for (int i = 0; i < n; i++)
		begin
			serial_in_line <= f[i];
			repeat (bit_cyc) @(posedge clock);
		end
	endtask
	task automatic glitch(input int len);
		serial_in_line <= 1'b0;
		repeat (len) @(posedge clock);
		serial_in_line <= 1'b1;
	endtask
	// ********************
	// Receiving side, samples mid-bit
	// ********************
	initial
	begin
		cap_cnt = 0;
		serial_in_line = 1'b1;
		forever
		begin
			@(negedge serial_out_line);
			repeat (bit_cyc / 2) @(posedge clock);
			for (int i = 0; i < 8; i++)
			begin
				repeat (bit_cyc) @(posedge clock);
				cap_byte[i] = serial_out_line;
			end
			if (par_mode != PARITY_NONE)
			begin
				repeat (bit_cyc) @(posedge clock);
				cap_par = serial_out_line;
			end
			repeat (bit_cyc) @(posedge clock);
			cap_stop = serial_out_line;
			cap_cnt++;
		end
	end
endmodule
